// [hw/seq_consts.svh]
// Offsets, field positions, reset values and timing counts of the sequencer.
// Assumes a single 20 MHz clock; included by its bare name.
`ifndef SEQ_CONSTS_SVH
`define SEQ_CONSTS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_MHZ 20
`define FILT_NS 1000
// Least time: round up to whole cycles
`define FILT_CYC ((`FILT_NS * `CLK_MHZ + 999) / 1000)

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFF_CTRL 8'h00
`define OFF_AI_CFG 8'h04
`define OFF_AI_RATE 8'h08
`define OFF_AI_LIMIT 8'h0c
`define DIR_STRIDE 8'h0c
`define OFF_AI_DATA 8'h1c
`define OFF_AO_DATA 8'h20
`define OFF_STATUS 8'h24
`define OFF_EVENT 8'h28
`define OFF_MASK 8'h2c
`define OFF_FILL 8'h30

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CTRL_START_BIT 0
`define CTRL_STOP_BIT 1
`define CTRL_STRIDE 2
`define CFG_CLK_EXT 0
`define CFG_START_EXT 1
`define CFG_STOP_EXT 2
`define CFG_CNT_EN 3
`define CFG_START_FALL 4
`define CFG_FILT_EN 7
`define CFG_NCH_LSB 8
`define EVT_DONE_LSB 0
`define EVT_ERR_LSB 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CFG_RST 16'h0000
`define RATE_RST 16'h00c7
`define LIMIT_RST 16'h0400
`define MASK_RST 4'h0

`endif

// [hw/seq_pkg.sv]
// Types shared by the sampling sequencer modules.
// Assumes nothing of its surroundings.
package seq_pkg;

    typedef logic [15:0] sample_t;

    typedef enum logic [1:0] {
        PACE_IDLE = 2'b00,
        PACE_ARMED = 2'b01,
        PACE_RUN = 2'b10
    } pace_state_t;

    typedef enum logic [1:0] {
        SCAN_IDLE = 2'b00,
        SCAN_WAIT = 2'b01,
        SCAN_ISSUE = 2'b10
    } scan_state_t;

endpackage : seq_pkg

// [hw/fifo_if.sv]
// Push/pop port of one sample buffer.
// Assumes producer and consumer share the buffer's clock.
`timescale 1ns/1ns

interface fifo_if #(parameter int WIDTH = 16, parameter int AW = 10);
    logic push;
    logic pop;
    logic [WIDTH-1:0] wdata;
    logic [WIDTH-1:0] rdata;
    logic full;
    logic empty;
    logic [AW:0] level;

    modport buffer(input push, input pop, input wdata,
                   output rdata, output full, output empty, output level);
    modport user(output push, output pop, output wdata,
                 input rdata, input full, input empty, input level);
endinterface : fifo_if

// [hw/ext_input_cond.sv]
// Digital filter and edge selector for one external control input.
// Assumes the input is synchronous to clock.
`timescale 1ns/1ns
`include "seq_consts.svh"

module ext_input_cond #(
    parameter int CYC = `FILT_CYC
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic raw,
    input wire logic filt_en,
    input wire logic fall_sel,
    output logic edge_hit
);
    localparam int CW = $clog2(CYC + 1);

    logic stable;
    logic next_stable;
    logic next_edge;
    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;

    // ----------------------------------------
    // Filter and edge
    // ----------------------------------------
    // A change is accepted only once it has stood CYC cycles
    always_comb begin
        next_stable = stable;
        next_cnt = '0;
        next_edge = 1'b0;
        if (raw != stable) begin
            if (!filt_en || cnt == CW'(CYC - 1)) begin
                next_stable = raw;
                next_edge = (raw == !fall_sel);
            end else begin
                next_cnt = cnt + CW'(1);
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            stable <= 1'b0;
            cnt <= '0;
            edge_hit <= 1'b0;
        end else begin
            stable <= next_stable;
            cnt <= next_cnt;
            edge_hit <= next_edge;
        end
    end

    a_filter_reject: assert property (@(posedge clock) disable iff (sys_rst)
        filt_en && raw != stable && cnt != CW'(CYC - 1) |=> stable == $past(stable))
        else $error("filtered input accepted too early");

    a_edge_polarity: assert property (@(posedge clock) disable iff (sys_rst)
        edge_hit |-> stable == !$past(fall_sel))
        else $error("edge reported on wrong polarity");

endmodule : ext_input_cond

// [hw/sample_buffer.sv]
// First-in first-out sample buffer held in flip-flops.
// Assumes push and pop come from logic on the same clock.
`timescale 1ns/1ns

module sample_buffer #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 1024
) (
    input wire logic clock,
    input wire logic sys_rst,
    fifo_if.buffer port
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW-1:0] next_wr_ptr;
    logic [AW-1:0] next_rd_ptr;
    logic [AW:0] next_count;
    logic do_push;
    logic do_pop;

    assign port.full = (count == (AW + 1)'(DEPTH));
    assign port.empty = (count == '0);
    assign port.level = count;
    assign port.rdata = mem[rd_ptr];
    // A push into a full buffer is dropped; the user flags it
    assign do_push = port.push && !port.full;
    assign do_pop = port.pop && !port.empty;

    always_comb begin
        next_wr_ptr = do_push ? wr_ptr + AW'(1) : wr_ptr;
        next_rd_ptr = do_pop ? rd_ptr + AW'(1) : rd_ptr;
        next_count = count;
        if (do_push && !do_pop) begin
            next_count = count + (AW + 1)'(1);
        end else if (do_pop && !do_push) begin
            next_count = count - (AW + 1)'(1);
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    // Storage has no reset: contents are only read below the fill level
    always_ff @(posedge clock) begin
        if (do_push) begin
            mem[wr_ptr] <= port.wdata;
        end
    end

    a_full_holds: assert property (@(posedge clock) disable iff (sys_rst)
        port.push && port.full && !port.pop |=> count == $past(count))
        else $error("buffer grew past its depth");

endmodule : sample_buffer

// [hw/analog_sampling_sequencer.sv]
// Sampling sequencer for an 8-in, 2-out analog board, with APB registers.
// Assumes converters answer on their handshake and external inputs are synchronous.
//
// How it works
// - Eight 16-bit input channels and two 16-bit output channels.
// - Pacing from internal timer or external sampling clock, software selected.
// - Conversion starts on software command or external start trigger.
// - Conversion stops on sample count, external stop trigger, or software.
// - Edge of external start, stop and clock inputs is software selected.
// - Optional one microsecond filter ignores short start and stop pulses.
// - Separate 1k-word buffers for input and output paths.
// - Once started, sampling continues without host action until a stop.
// - Errors and events reported on one interrupt request line.
`timescale 1ns/1ns
`include "seq_consts.svh"

module analog_sampling_sequencer #(
    parameter int DEPTH = 1024,
    parameter int FILT_CYC = `FILT_CYC
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] ext_start,
    input wire logic [1:0] ext_stop,
    input wire logic [1:0] ext_clock,
    output logic adc_start,
    output logic [2:0] adc_channel,
    input wire logic adc_done,
    input wire logic [15:0] adc_data,
    output logic dac_load,
    output logic [0:0] dac_channel,
    output logic [15:0] dac_data,
    output logic inta
);
    localparam int AW = $clog2(DEPTH);

    logic [15:0] cfg [2];
    logic [15:0] rate [2];
    logic [15:0] limit [2];
    logic [3:0] evt;
    logic [3:0] mask;
    logic [15:0] next_cfg [2];
    logic [15:0] next_rate [2];
    logic [15:0] next_limit [2];
    logic [3:0] next_evt;
    logic [3:0] next_mask;
    logic [3:0] evt_set;
    logic [1:0] sw_start;
    logic [1:0] sw_stop;
    logic [1:0] tick_v;
    logic [1:0] run_v;
    logic [1:0] armed_v;
    logic [1:0] done_v;
    logic [5:0] edge_v;
    logic access;
    logic setup;
    logic mapped;
    logic [31:0] rd_val;
    logic rd_had;
    logic next_rd_had;
    logic [31:0] next_prdata;
    logic ai_err;
    logic ao_err;

    fifo_if #(.WIDTH(16), .AW(AW)) ai_buf();
    fifo_if #(.WIDTH(16), .AW(AW)) ao_buf();

    sample_buffer #(.WIDTH(16), .DEPTH(DEPTH)) ai_store (
        .clock(clock),
        .sys_rst(sys_rst),
        .port(ai_buf)
    );

    sample_buffer #(.WIDTH(16), .DEPTH(DEPTH)) ao_store (
        .clock(clock),
        .sys_rst(sys_rst),
        .port(ao_buf)
    );

    // ----------------------------------------
    // Pacing, one copy per direction (0 input, 1 output)
    // ----------------------------------------
    for (genvar d = 0; d < 2; d++) begin : g_dir
        logic [2:0] raw_in;
        seq_pkg::pace_state_t st;
        seq_pkg::pace_state_t next_st;
        logic [15:0] timer;
        logic [15:0] next_timer;
        logic [15:0] scans;
        logic [15:0] next_scans;
        logic tick;
        logic stop;
        logic clk_ext;

        assign raw_in = {ext_clock[d], ext_stop[d], ext_start[d]};
        assign clk_ext = cfg[d][`CFG_CLK_EXT];

        for (genvar k = 0; k < 3; k++) begin : g_in
            ext_input_cond #(.CYC(FILT_CYC)) cond (
                .clock(clock),
                .sys_rst(sys_rst),
                .raw(raw_in[k]),
                // The sampling clock input is never filtered
                .filt_en(k < 2 ? cfg[d][`CFG_FILT_EN] : 1'b0),
                .fall_sel(cfg[d][`CFG_START_FALL + k]),
                .edge_hit(edge_v[d * 3 + k])
            );
        end

        always_comb begin
            next_st = st;
            next_timer = timer;
            next_scans = scans;
            tick = 1'b0;
            stop = 1'b0;
            unique case (st)
                seq_pkg::PACE_IDLE: begin
                    if (sw_start[d]) begin
                        next_scans = '0;
                        next_timer = rate[d];
                        next_st = cfg[d][`CFG_START_EXT] ? seq_pkg::PACE_ARMED
                                                         : seq_pkg::PACE_RUN;
                    end
                end
                seq_pkg::PACE_ARMED: begin
                    if (sw_stop[d]) begin
                        next_st = seq_pkg::PACE_IDLE;
                    end else if (edge_v[d * 3]) begin
                        next_timer = rate[d];
                        next_st = seq_pkg::PACE_RUN;
                    end
                end
                seq_pkg::PACE_RUN: begin
                    if (clk_ext) begin
                        tick = edge_v[d * 3 + 2];
                    end else begin
                        tick = (timer == 16'h0000);
                        next_timer = tick ? rate[d] : timer - 16'h0001;
                    end
                    if (tick) begin
                        next_scans = scans + 16'h0001;
                    end
                    stop = sw_stop[d]
                        || (cfg[d][`CFG_STOP_EXT] && edge_v[d * 3 + 1])
                        || (cfg[d][`CFG_CNT_EN] && tick && next_scans == limit[d]);
                    // Otherwise keep pacing with no host help
                    next_st = stop ? seq_pkg::PACE_IDLE : seq_pkg::PACE_RUN;
                end
                default: next_st = seq_pkg::PACE_IDLE;
            endcase
        end

        always_ff @(posedge clock or posedge sys_rst) begin
            if (sys_rst) begin
                st <= seq_pkg::PACE_IDLE;
                timer <= 16'h0000;
                scans <= 16'h0000;
            end else begin
                st <= next_st;
                timer <= next_timer;
                scans <= next_scans;
            end
        end

        assign tick_v[d] = tick;
        assign run_v[d] = (st == seq_pkg::PACE_RUN);
        assign armed_v[d] = (st == seq_pkg::PACE_ARMED);
        assign done_v[d] = run_v[d] && stop;

        a_soft_start: assert property (@(posedge clock) disable iff (sys_rst)
            st == seq_pkg::PACE_IDLE && sw_start[d] && !cfg[d][`CFG_START_EXT]
            |=> st == seq_pkg::PACE_RUN)
            else $error("software start did not run");
        a_count_stop: assert property (@(posedge clock) disable iff (sys_rst)
            st == seq_pkg::PACE_RUN && cfg[d][`CFG_CNT_EN] && tick
            && scans == limit[d] - 16'h0001 |=> st == seq_pkg::PACE_IDLE)
            else $error("sample count reached without stop");
        a_keeps_running: assert property (@(posedge clock) disable iff (sys_rst)
            st == seq_pkg::PACE_RUN && !sw_stop[d] && !edge_v[d * 3 + 1]
            && !(cfg[d][`CFG_CNT_EN] && tick) |=> st == seq_pkg::PACE_RUN)
            else $error("sampling stopped without a cause");
        a_timer_pace: assert property (@(posedge clock) disable iff (sys_rst)
            st == seq_pkg::PACE_RUN && !clk_ext && tick ##1 st == seq_pkg::PACE_RUN
            |-> timer == $past(rate[d]))
            else $error("timer not reloaded at a tick");
    end

    // ----------------------------------------
    // Input scan: one conversion per channel per tick
    // ----------------------------------------
    seq_pkg::scan_state_t ai_st;
    seq_pkg::scan_state_t next_ai_st;
    logic [2:0] next_adc_channel;
    logic next_adc_start;
    logic [2:0] ai_nch;

    assign ai_nch = cfg[0][`CFG_NCH_LSB +: 3];
    assign ai_buf.wdata = adc_data;
    assign ai_buf.push = (ai_st == seq_pkg::SCAN_WAIT) && adc_done;

    always_comb begin
        next_ai_st = ai_st;
        next_adc_channel = adc_channel;
        next_adc_start = 1'b0;
        // A tick during a scan, or a full buffer, is an overrun
        ai_err = (tick_v[0] && ai_st != seq_pkg::SCAN_IDLE) || (ai_buf.push && ai_buf.full);
        unique case (ai_st)
            seq_pkg::SCAN_IDLE: begin
                if (tick_v[0]) begin
                    next_adc_channel = 3'h0;
                    next_adc_start = 1'b1;
                    next_ai_st = seq_pkg::SCAN_WAIT;
                end
            end
            seq_pkg::SCAN_WAIT: begin
                if (adc_done) begin
                    if (adc_channel == ai_nch) begin
                        next_ai_st = seq_pkg::SCAN_IDLE;
                    end else begin
                        next_adc_channel = adc_channel + 3'h1;
                        next_adc_start = 1'b1;
                    end
                end
            end
            default: next_ai_st = seq_pkg::SCAN_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ai_st <= seq_pkg::SCAN_IDLE;
            adc_channel <= 3'h0;
            adc_start <= 1'b0;
        end else begin
            ai_st <= next_ai_st;
            adc_channel <= next_adc_channel;
            adc_start <= next_adc_start;
        end
    end

    a_adc_chan_range: assert property (@(posedge clock) disable iff (sys_rst)
        adc_start |-> adc_channel <= ai_nch)
        else $error("conversion outside configured channels");
    a_push_done: assert property (@(posedge clock) disable iff (sys_rst)
        ai_buf.push && !ai_buf.full && !ai_buf.pop
        |=> ai_buf.level == $past(ai_buf.level) + (AW + 1)'(1))
        else $error("converted sample not stored");

    // ----------------------------------------
    // Output update: one buffer word per channel per tick
    // ----------------------------------------
    seq_pkg::scan_state_t ao_st;
    seq_pkg::scan_state_t next_ao_st;
    logic [0:0] ao_chan;
    logic [0:0] next_ao_chan;
    logic next_dac_load;
    logic [0:0] next_dac_channel;
    logic [15:0] next_dac_data;

    assign ao_buf.pop = (ao_st == seq_pkg::SCAN_ISSUE);
    assign ai_buf.pop = access && !pwrite && paddr == `OFF_AI_DATA && rd_had;

    always_comb begin
        next_ao_st = ao_st;
        next_ao_chan = ao_chan;
        next_dac_load = 1'b0;
        next_dac_channel = dac_channel;
        next_dac_data = dac_data;
        ao_err = (tick_v[1] && ao_st != seq_pkg::SCAN_IDLE) || (ao_buf.pop && ao_buf.empty);
        unique case (ao_st)
            seq_pkg::SCAN_IDLE: begin
                if (tick_v[1]) begin
                    next_ao_chan = 1'b0;
                    next_ao_st = seq_pkg::SCAN_ISSUE;
                end
            end
            seq_pkg::SCAN_ISSUE: begin
                // An empty buffer leaves the channel at its last value
                if (!ao_buf.empty) begin
                    next_dac_load = 1'b1;
                    next_dac_channel = ao_chan;
                    next_dac_data = ao_buf.rdata;
                end
                if (ao_chan == cfg[1][`CFG_NCH_LSB]) begin
                    next_ao_st = seq_pkg::SCAN_IDLE;
                end else begin
                    next_ao_chan = ao_chan + 1'b1;
                end
            end
            default: next_ao_st = seq_pkg::SCAN_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ao_st <= seq_pkg::SCAN_IDLE;
            ao_chan <= 1'b0;
            dac_load <= 1'b0;
            dac_channel <= 1'b0;
            dac_data <= 16'h0000;
        end else begin
            ao_st <= next_ao_st;
            ao_chan <= next_ao_chan;
            dac_load <= next_dac_load;
            dac_channel <= next_dac_channel;
            dac_data <= next_dac_data;
        end
    end

    // ----------------------------------------
    // APB registers
    // ----------------------------------------
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign pready = 1'b1;
    assign evt_set = {ao_err, ai_err, done_v};
    assign inta = |(evt & mask);
    assign ao_buf.push = access && pwrite && paddr == `OFF_AO_DATA;
    assign ao_buf.wdata = pwdata[15:0];

    for (genvar d = 0; d < 2; d++) begin : g_ctrl
        assign sw_start[d] = access && pwrite && paddr == `OFF_CTRL
            && pwdata[d * `CTRL_STRIDE + `CTRL_START_BIT];
        assign sw_stop[d] = access && pwrite && paddr == `OFF_CTRL
            && pwdata[d * `CTRL_STRIDE + `CTRL_STOP_BIT];
    end

    always_comb begin
        mapped = (paddr <= `OFF_FILL) && (paddr[1:0] == 2'b00);
        rd_val = 32'h0000_0000;
        for (int d = 0; d < 2; d++) begin
            if (paddr == `OFF_AI_CFG + 8'(d) * `DIR_STRIDE) rd_val = {16'h0000, cfg[d]};
            if (paddr == `OFF_AI_RATE + 8'(d) * `DIR_STRIDE) rd_val = {16'h0000, rate[d]};
            if (paddr == `OFF_AI_LIMIT + 8'(d) * `DIR_STRIDE) rd_val = {16'h0000, limit[d]};
        end
        if (paddr == `OFF_AI_DATA) rd_val = {16'h0000, ai_buf.empty ? 16'h0000 : ai_buf.rdata};
        if (paddr == `OFF_STATUS) rd_val = {28'h0000000, armed_v, run_v};
        if (paddr == `OFF_EVENT) rd_val = {28'h0000000, evt};
        if (paddr == `OFF_MASK) rd_val = {28'h0000000, mask};
        if (paddr == `OFF_FILL) begin
            rd_val = {16'(ao_buf.level), 16'(ai_buf.level)};
        end
        pslverr = access && (!mapped || (ao_buf.push && ao_buf.full));
        next_prdata = setup && !pwrite ? rd_val : prdata;
        next_rd_had = setup ? !ai_buf.empty : rd_had;
        for (int d = 0; d < 2; d++) begin
            next_cfg[d] = cfg[d];
            next_rate[d] = rate[d];
            next_limit[d] = limit[d];
            if (access && pwrite && paddr == `OFF_AI_CFG + 8'(d) * `DIR_STRIDE) begin
                next_cfg[d] = pwdata[15:0];
            end
            if (access && pwrite && paddr == `OFF_AI_RATE + 8'(d) * `DIR_STRIDE) begin
                next_rate[d] = pwdata[15:0];
            end
            if (access && pwrite && paddr == `OFF_AI_LIMIT + 8'(d) * `DIR_STRIDE) begin
                next_limit[d] = pwdata[15:0];
            end
        end
        next_mask = (access && pwrite && paddr == `OFF_MASK) ? pwdata[3:0] : mask;
        // Write one to clear; a new event in the same cycle wins
        next_evt = evt;
        if (access && pwrite && paddr == `OFF_EVENT) begin
            next_evt = evt & ~pwdata[3:0];
        end
        next_evt = next_evt | evt_set;
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            for (int d = 0; d < 2; d++) begin
                cfg[d] <= `CFG_RST;
                rate[d] <= `RATE_RST;
                limit[d] <= `LIMIT_RST;
            end
            evt <= 4'h0;
            mask <= `MASK_RST;
            prdata <= 32'h0000_0000;
            rd_had <= 1'b0;
        end else begin
            cfg <= next_cfg;
            rate <= next_rate;
            limit <= next_limit;
            evt <= next_evt;
            mask <= next_mask;
            prdata <= next_prdata;
            rd_had <= next_rd_had;
        end
    end

    a_irq_raise: assert property (@(posedge clock) disable iff (sys_rst)
        |(evt_set & mask) |=> inta)
        else $error("unmasked event did not raise the interrupt");

endmodule : analog_sampling_sequencer

// [verif/adc_model.sv]
// Behavioural input converter for the sequencer bench.
// Assumes one clock; answers each start after four cycles.
`timescale 1ns/1ns

module adc_model (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic adc_start,
    input wire logic [2:0] adc_channel,
    output logic adc_done,
    output logic [15:0] adc_data
);
    logic [2:0] pend;
    logic [2:0] ch;
    logic [12:0] n;
    // Data carries channel and running count so order is visible
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pend <= 3'h0;
            ch <= 3'h0;
            n <= 13'h0;
            adc_done <= 1'b0;
            adc_data <= 16'h0;
        end else begin
            pend <= {pend[1:0], adc_start};
            if (adc_start) begin
                ch <= adc_channel;
            end
            adc_done <= pend[2];
            if (pend[2]) begin
                adc_data <= {ch, n};
                n <= n + 13'h1;
            end else begin
                // Not valid outside the done pulse
                adc_data <= ~adc_data;
            end
        end
    end
endmodule : adc_model

// [verif/analog_sampling_sequencer_bench.sv]
// Self-checking bench: APB tasks, converter model, output capture.
// Assumes the sequencer and its package and headers compile first.
`timescale 1ns/1ns

module analog_sampling_sequencer_bench;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, d;
    logic pready, pslverr, adc_start, adc_done, dac_load, inta, err_seen;
    logic [1:0] ext_start = 2'b11;
    logic [1:0] ext_stop = 2'b00, ext_clock = 2'b00;
    logic [2:0] adc_channel;
    logic [15:0] adc_data, dac_data;
    logic [0:0] dac_channel;
    logic [31:0] dq[$];
    int bad_count = 0, comparisons = 0;
    analog_sampling_sequencer #(.DEPTH(32), .FILT_CYC(2)) analog_sampling_sequencer_i (
        .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_start(ext_start),
        .ext_stop(ext_stop), .ext_clock(ext_clock), .adc_start(adc_start),
        .adc_channel(adc_channel), .adc_done(adc_done), .adc_data(adc_data),
        .dac_load(dac_load), .dac_channel(dac_channel), .dac_data(dac_data),
        .inta(inta));
    adc_model adc_model_i (.clock(clock), .sys_rst(sys_rst), .adc_start(adc_start),
        .adc_channel(adc_channel), .adc_done(adc_done), .adc_data(adc_data));
    initial forever #25 clock = ~clock;
    always @(posedge clock) if (dac_load === 1'b1) dq.push_back({15'h0, dac_channel, dac_data});
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        d = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask : xfer
    // Bounded poll of one event bit
    task automatic wait_evt(input int b);
        for (int k = 0; k < 300; k++) begin
            xfer(1'b0, 8'h28, 32'h0);
            if (d[b] === 1'b1) break;
        end
    endtask : wait_evt
    task automatic conclude;
        if (bad_count == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude
    initial begin
        #1000000;
        bad_count++;
        conclude();
    end
    initial begin
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        xfer(1'b0, 8'h08, 32'h0); chk(d, 32'h00c7);
        xfer(1'b0, 8'h0c, 32'h0); chk(d, 32'h0400);
        xfer(1'b0, 8'h34, 32'h0); chk(d, 32'h0);
        // Eight channels, two timed scans, then count stop
        xfer(1'b1, 8'h04, 32'h0708);
        xfer(1'b1, 8'h08, 32'h003f);
        xfer(1'b1, 8'h0c, 32'h0002);
        xfer(1'b1, 8'h00, 32'h1);
        wait_evt(0); chk({31'h0, d[0]}, 32'h1);
        // The stop does not abort the last scan: let it finish
        repeat (50) @(posedge clock);
        xfer(1'b0, 8'h30, 32'h0); chk(d, 32'h10);
        for (int i = 0; i < 16; i++) begin
            xfer(1'b0, 8'h1c, 32'h0); chk(d, {16'h0, i[2:0], i[12:0]});
        end
        xfer(1'b1, 8'h2c, 32'h1);
        chk({31'h0, inta}, 32'h1);
        xfer(1'b1, 8'h28, 32'h1);
        chk({31'h0, inta}, 32'h0);
        xfer(1'b1, 8'h20, 32'h1234);
        xfer(1'b1, 8'h20, 32'habcd);
        xfer(1'b1, 8'h10, 32'h0108);
        xfer(1'b1, 8'h14, 32'h001f);
        xfer(1'b1, 8'h18, 32'h0001);
        xfer(1'b1, 8'h00, 32'h4);
        wait_evt(1); chk({31'h0, d[1]}, 32'h1);
        repeat (4) @(posedge clock);
        chk(dq.size(), 32'h2);
        chk(dq[0], 32'h1234);
        chk(dq[1], 32'h1abcd);
        // Overfill the output buffer: the word past its depth is refused
        for (int i = 0; i < 33; i++) xfer(1'b1, 8'h20, 32'h0);
        chk({31'h0, err_seen}, 32'h1);
        xfer(1'b0, 8'h30, 32'h0); chk(d, 32'h0020_0000);
        // Filtered falling-edge start: a one-cycle glitch must not start
        xfer(1'b1, 8'h04, 32'h0092);
        xfer(1'b1, 8'h00, 32'h1);
        xfer(1'b0, 8'h24, 32'h0); chk(d, 32'h4);
        ext_start <= 2'b10;
        @(posedge clock);
        ext_start <= 2'b11;
        repeat (5) @(posedge clock);
        xfer(1'b0, 8'h24, 32'h0); chk(d, 32'h4);
        ext_start <= 2'b10;
        repeat (6) @(posedge clock);
        xfer(1'b0, 8'h24, 32'h0); chk(d, 32'h1);
        xfer(1'b1, 8'h00, 32'h2);
        xfer(1'b0, 8'h24, 32'h0); chk(d, 32'h0);
        // External sampling clock paces one scan, external stop ends it
        xfer(1'b1, 8'h04, 32'h0005);
        xfer(1'b1, 8'h00, 32'h1);
        ext_clock <= 2'b01;
        repeat (20) @(posedge clock);
        xfer(1'b0, 8'h24, 32'h0); chk(d, 32'h1);
        ext_stop <= 2'b01;
        repeat (4) @(posedge clock);
        xfer(1'b0, 8'h24, 32'h0); chk(d, 32'h0);
        xfer(1'b0, 8'h1c, 32'h0); chk(d, 32'h0010);
        conclude();
    end
endmodule : analog_sampling_sequencer_bench
